/* File: rtl/fepcs_defs.vh */
// constants for the fast ethernet coding path
`ifndef FEPCS_DEFS_VH
`define FEPCS_DEFS_VH

`define FEPCS_CG_IDLE      5'h1f
`define FEPCS_CG_J         5'h18
`define FEPCS_CG_K         5'h11
`define FEPCS_CG_T         5'h0d
`define FEPCS_CG_R         5'h07
`define FEPCS_CG_HALT      5'h04
`define FEPCS_GROUP_LAST   4
`define FEPCS_SEED_LOW     7'h7f
`define FEPCS_RUN_MAX      6'h3f
`define FEPCS_MLT_ZERO     2'h0
`define FEPCS_LFSR_W       11
`define FEPCS_LFSR_FILL    11'h7f0
`define FEPCS_SYNC_IDLES   12
`define FEPCS_SYNC_BITS    60
`define FEPCS_HOLD_BITS    58
`define FEPCS_HOLD_US      722
`define FEPCS_CLK_MHZ      125
`define FEPCS_HOLD_CYC     (`FEPCS_HOLD_US * `FEPCS_CLK_MHZ)

`endif

/* File: rtl/fepcs_enc_rom.v */
// 4b to 5b data code-group lookup with registered output
`timescale 1ns/1ps
module fepcs_enc_rom (
    input  wire       sys_clk,   // symbol clock
    input  wire       nrst,      // async reset, active low
    input  wire [3:0] nibble,    // nibble to map
    output reg  [4:0] codeGroup  // mapped code-group, one cycle later
);
    reg [4:0] code;

    always @* begin
        case (nibble)
            4'h0: code = 5'h1e;
            4'h1: code = 5'h09;
            4'h2: code = 5'h14;
            4'h3: code = 5'h15;
            4'h4: code = 5'h0a;
            4'h5: code = 5'h0b;
            4'h6: code = 5'h0e;
            4'h7: code = 5'h0f;
            4'h8: code = 5'h12;
            4'h9: code = 5'h13;
            4'ha: code = 5'h16;
            4'hb: code = 5'h17;
            4'hc: code = 5'h1a;
            4'hd: code = 5'h1b;
            4'he: code = 5'h1c;
            default: code = 5'h1d;
        endcase
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            codeGroup <= 5'h1e;
        end else begin
            codeGroup <= code;
        end
    end
endmodule

/* File: rtl/fepcs_lfsr.v */
// 11-bit key generator, x^11 + x^9 + 1, closed loop unless injEn
`timescale 1ns/1ps
`include "fepcs_defs.vh"
module fepcs_lfsr (
    input  wire        sys_clk,  // symbol clock
    input  wire        nrst,     // async reset, active low
    input  wire        load,     // load seed or forced state
    input  wire [10:0] loadVal,  // value taken on load
    input  wire        step,     // advance one bit
    input  wire        injEn,    // open loop: shift in injBit
    input  wire        injBit,   // bit shifted in when injEn
    output wire        key       // key bit
);
    reg  [10:0] state_reg;
    wire        fb;

    assign fb  = state_reg[10] ^ state_reg[8];
    assign key = fb;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= `FEPCS_LFSR_FILL;
        end else if (load) begin
            state_reg <= loadVal;
        end else if (step) begin
            state_reg <= {state_reg[9:0], injEn ? injBit : fb};
        end
    end
endmodule

/* File: rtl/fepcs_coding.v */
// 100 Mb/s coding path: encode, scramble, nrzi, mlt-3 and receive descramble
// ****************************************
// What this block does
// R1: map each mac nibble to a 5-bit code-group
// R2: replace first preamble byte with J then K
// R3: map remaining preamble and data nibbles to data code-groups
// R4: on transmit enable drop, send T then R
// R5: after T/R, send idle until transmit enable returns
// R6: scrambler is a closed loop 11-bit lfsr
// R7: xor each serial encoder bit with lfsr output
// R8: scrambler seed taken from address straps bits 4 to 1
// R9: nrzi encode the scrambled stream
// R10: split nrzi into two drive streams, ones alternating
// R11: transmit pair carries only mlt-3, no binary mode
// R12: 100M signal detect ignores 10M link and fast link pulses
// R13: convert received three-level symbols to nrzi bits
// R14: decode nrzi to nrz before descrambling
// R15: group received bits into 5-bit symbols
// R16: descramble with identical key sequence by xor
// R17: lock after 12 idle code-groups, then emit unaligned 5-bit groups
// R18: start 722 us hold timer on lock
// R19: 58 idle bit times restart hold timer
// R20: hold expiry drops lock and restarts acquisition
// R21: standard 4b5b table, idle 11111, halt 00100
// R22: scrambler bypass option
// R23: serial stages advance one bit per symbol clock
// R24: reset: unlocked, timer stopped, transmitter sends idle
// ****************************************
`timescale 1ns/1ps
`include "fepcs_defs.vh"
module fepcs_coding #(
    parameter HOLD_CYC = `FEPCS_HOLD_CYC  // hold interval in symbol clocks
) (
    input  wire       sys_clk,                // 125 MHz symbol clock
    input  wire       nrst,                   // async reset, active low
    input  wire       txEnable,               // mac transmit enable
    input  wire [3:0] txNibble,               // mac transmit nibble
    input  wire       txError,                // mac transmit error, sends halt
    input  wire [4:0] station_address_straps, // address straps
    input  wire       scrBypass,              // pass encoder output unscrambled
    input  wire       rxSymValid,             // equalized symbol present
    input  wire [1:0] rxMlt,                  // 01 plus, 11 minus, 00 zero
    input  wire       rxEnergy,               // 100M energy from front end
    input  wire       rxPulseLike,            // energy is 10M or fast link pulse
    output reg        txDriveA,               // drive stream, positive level
    output reg        txDriveB,               // drive stream, negative level
    output reg        sigDetect,              // 100M signal detect
    output reg        rxLocked,               // descrambler synchronized
    output reg  [4:0] rxSymbol,               // unaligned 5-bit group
    output reg        rxSymStrobe             // rxSymbol new, one cycle
);
    // ****************************************
    // transmit framer
    // ****************************************
    localparam TX_IDLE = 3'd0;
    localparam TX_J    = 3'd1;
    localparam TX_K    = 3'd2;
    localparam TX_DATA = 3'd3;
    localparam TX_T    = 3'd4;
    localparam TX_R    = 3'd5;

    // last bit position of a code-group, shared by transmit and receive
    localparam [2:0] GROUP_LAST = `FEPCS_GROUP_LAST;

    reg  [2:0] txState_reg;
    reg  [2:0] txState_next;
    reg  [2:0] bitCnt_reg;
    reg  [4:0] shift_reg;
    reg  [4:0] load5;
    reg        errPend_reg;
    wire [4:0] dataCg;
    wire       groupEnd;

    assign groupEnd = (bitCnt_reg == GROUP_LAST);

    fepcs_enc_rom uEnc (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .nibble    (txNibble),
        .codeGroup (dataCg)
    ); // R21

    always @* begin
        txState_next = txState_reg;
        load5        = `FEPCS_CG_IDLE; // R5
        case (txState_reg)
            TX_IDLE: begin
                if (txEnable) begin
                    txState_next = TX_J;
                    load5        = `FEPCS_CG_J; // R2
                end
            end
            // k follows j unconditionally: the pair stands for one preamble byte
            TX_J: begin
                txState_next = TX_K;
                load5        = `FEPCS_CG_K; // R2
            end
            TX_K, TX_DATA: begin
                if (txEnable) begin
                    txState_next = TX_DATA;
                    load5        = errPend_reg ? `FEPCS_CG_HALT : dataCg; // R1 R3
                end else begin
                    txState_next = TX_T;
                    load5        = `FEPCS_CG_T; // R4
                end
            end
            TX_T: begin
                txState_next = TX_R;
                load5        = `FEPCS_CG_R; // R4
            end
            default: begin
                txState_next = TX_IDLE;
                load5        = `FEPCS_CG_IDLE; // R5
            end
        endcase
    end

    // nibble is sampled once per code-group, 5 clocks apart
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            txState_reg <= TX_IDLE; // R24
            bitCnt_reg  <= 3'd0;
            shift_reg   <= `FEPCS_CG_IDLE;
            errPend_reg <= 1'b0;
        end else begin
            bitCnt_reg  <= groupEnd ? 3'd0 : bitCnt_reg + 3'd1; // R23
            errPend_reg <= txError;
            if (groupEnd) begin
                txState_reg <= txState_next;
                shift_reg   <= load5;
            end else begin
                shift_reg <= {shift_reg[3:0], 1'b0};
            end
        end
    end

    // ****************************************
    // scrambler, nrzi and mlt-3 split
    // ****************************************
    reg         seedDone_reg;
    reg         nrzi_reg;
    reg         lastWasA_reg;
    wire        txKey;
    wire        scrBit;
    wire        nrziNext;
    wire        backToZero;
    wire [10:0] seed;

    // low seed bits fixed high so no strap setting can give an all-zero state
    assign seed       = {station_address_straps[4:1], `FEPCS_SEED_LOW}; // R8
    assign scrBit     = shift_reg[4] ^ (scrBypass ? 1'b0 : txKey); // R7 R22
    assign nrziNext   = nrzi_reg ^ scrBit; // R9
    // side flips as the line returns to zero, so the next nonzero level takes the other sign
    assign backToZero = scrBit & nrzi_reg;

    fepcs_lfsr uTxLfsr (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .load    (!seedDone_reg),
        .loadVal (seed),
        .step    (1'b1),
        .injEn   (1'b0),
        .injBit  (1'b0),
        .key     (txKey)
    ); // R6

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seedDone_reg <= 1'b0;
            nrzi_reg     <= 1'b0;
            lastWasA_reg <= 1'b0;
            txDriveA     <= 1'b0;
            txDriveB     <= 1'b0;
        end else begin
            seedDone_reg <= 1'b1;
            nrzi_reg     <= nrziNext; // R9
            if (backToZero) begin
                lastWasA_reg <= !lastWasA_reg; // R10
            end
            // one stream high per mlt-3 nonzero level; only mlt-3 leaves here
            txDriveA <= nrziNext & !lastWasA_reg; // R10 R11
            txDriveB <= nrziNext & lastWasA_reg; // R10 R11
        end
    end

    // ****************************************
    // receive decode
    // ****************************************
    reg        nrziPrev_reg;
    reg        rxNrz;
    wire       rxNrzi;

    // either nonzero level counts as high; the sign carries no data
    assign rxNrzi = (rxMlt != `FEPCS_MLT_ZERO); // R13

    always @* begin
        rxNrz = rxNrzi ^ nrziPrev_reg; // R14
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            nrziPrev_reg <= 1'b0;
            sigDetect    <= 1'b0;
        end else begin
            sigDetect <= rxEnergy & !rxPulseLike; // R12
            if (rxSymValid) begin
                nrziPrev_reg <= rxNrzi;
            end
        end
    end

    // ****************************************
    // descrambler with hold timer
    // ****************************************
    localparam [5:0]  SYNC_BITS = `FEPCS_SYNC_BITS; // 12 idles of 5 bits
    localparam [5:0]  HOLD_BITS = `FEPCS_HOLD_BITS;
    localparam [5:0]  RUN_MAX   = `FEPCS_RUN_MAX;
    localparam [16:0] HOLD_LOAD = HOLD_CYC;

    reg  [5:0]  onesRun_reg;
    reg  [16:0] hold_reg;
    reg  [4:0]  deser_reg;
    reg  [2:0]  rxCnt_reg;
    wire        rxKey;
    wire        udBit;
    wire        holdRun;
    wire        holdExpire;
    wire        runSync;
    wire        runHold;

    assign udBit      = rxNrz ^ rxKey; // R16
    assign holdRun    = (hold_reg != 17'd0);
    assign holdExpire = rxLocked && !holdRun;
    // run counts include the current bit; compared before saturation can wrap
    assign runSync    = udBit && (onesRun_reg == SYNC_BITS - 6'd1);
    assign runHold    = udBit && (onesRun_reg >= HOLD_BITS - 6'd1);

    // unlocked: lfsr fed from line assuming idle, so it trains itself
    fepcs_lfsr uRxLfsr (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .load    (holdExpire), // R20
        .loadVal (`FEPCS_LFSR_FILL),
        .step    (rxSymValid), // R23
        .injEn   (!rxLocked),
        .injBit  (!rxNrz),
        .key     (rxKey)
    ); // R16

    // lock supervisor: run of descrambled ones and the hold countdown
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            onesRun_reg <= 6'd0;
            hold_reg    <= 17'd0; // R24
            rxLocked    <= 1'b0; // R24
        end else if (holdExpire) begin
            rxLocked    <= 1'b0; // R20
            onesRun_reg <= 6'd0;
        end else if (rxSymValid) begin
            onesRun_reg <= udBit ? ((onesRun_reg == RUN_MAX) ? onesRun_reg : onesRun_reg + 6'd1) : 6'd0;
            if (rxLocked) begin
                // every idle bit past the threshold keeps the timer full, so steady idle never drops lock
                hold_reg <= runHold ? HOLD_LOAD : hold_reg - 17'd1; // R19
            end else if (runSync) begin
                rxLocked <= 1'b1; // R17
                hold_reg <= HOLD_LOAD; // R18
            end
        end
    end

    // serial to parallel, groups released only while locked
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            deser_reg   <= 5'h00;
            rxCnt_reg   <= 3'd0;
            rxSymbol    <= 5'h00;
            rxSymStrobe <= 1'b0;
        end else begin
            rxSymStrobe <= 1'b0;
            if (holdExpire) begin
                rxCnt_reg <= 3'd0; // R20
            end else if (rxSymValid) begin
                deser_reg <= {deser_reg[3:0], udBit};
                rxCnt_reg <= (rxCnt_reg == GROUP_LAST) ? 3'd0 : rxCnt_reg + 3'd1;
                if (rxLocked && rxCnt_reg == GROUP_LAST) begin
                    rxSymbol    <= {deser_reg[3:0], udBit}; // R15 R17
                    rxSymStrobe <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: verif/fepcs_coding_asserts.sv */
// port checker for the coding path
`timescale 1ns/1ps
module fepcs_coding_asserts #(
    parameter HOLD_CYC = 200 // hold interval
) (
    input wire sys_clk,     // clock
    input wire nrst,        // reset
    input wire rxSymValid,  // line bit
    input wire rxEnergy,    // energy
    input wire rxPulseLike, // pulses only
    input wire txDriveA,    // plus drive
    input wire txDriveB,    // minus drive
    input wire sigDetect,   // detect
    input wire rxLocked,    // lock
    input wire rxSymStrobe  // group strobe
);
// ****************
// helpers and checks
// ****************
reg        lastA_reg;
reg        seen_reg;
reg [6:0]  run_reg;
reg [31:0] lock_reg;
always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        lastA_reg <= 1'b0;
        seen_reg  <= 1'b0;
        run_reg   <= 7'h00;
        lock_reg  <= 32'h0;
    end else begin
        if (txDriveA | txDriveB) begin
            lastA_reg <= txDriveA;
            seen_reg  <= 1'b1;
        end
        run_reg  <= rxSymValid ? run_reg + {6'h00, run_reg != 7'h7f} : 7'h00;
        lock_reg <= rxLocked ? lock_reg + 32'h1 : 32'h0;
    end
end
default clocking dc @(posedge sys_clk); endclocking
default disable iff (!nrst);
AST_DRIVE_EXCL: assert property (!(txDriveA && txDriveB))
    else $error("both drives high");
AST_DRIVE_ALT: assert property ($rose(txDriveA | txDriveB) && seen_reg |-> txDriveA != lastA_reg)
    else $error("drive side repeated");
AST_SIG_PULSE: assert property (rxEnergy && rxPulseLike |=> !sigDetect)
    else $error("detect on pulses");
AST_SIG_DATA: assert property (rxEnergy && !rxPulseLike |=> sigDetect)
    else $error("detect missing");
AST_LOCK_RUN: assert property ($rose(rxLocked) |-> run_reg >= 7'h3c)
    else $error("lock too early");
AST_STROBE_GAP: assert property (rxSymStrobe |=> !rxSymStrobe [*4])
    else $error("groups too close");
AST_HOLD_MIN: assert property ($fell(rxLocked) |-> lock_reg >= HOLD_CYC - 2)
    else $error("lock dropped before hold");
AST_RESET_UNLOCK: assert property ($rose(nrst) |-> !rxLocked [*8])
    else $error("locked after reset");
endmodule
bind fepcs_coding fepcs_coding_asserts #(.HOLD_CYC(HOLD_CYC)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .rxSymValid(rxSymValid), .rxEnergy(rxEnergy), .rxPulseLike(rxPulseLike), .txDriveA(txDriveA),
    .txDriveB(txDriveB), .sigDetect(sigDetect), .rxLocked(rxLocked), .rxSymStrobe(rxSymStrobe));

/* File: verif/fepcs_link_partner.sv */
// cable and far end model, echoes our drive levels back
`timescale 1ns/1ps
module fepcs_link_partner (
    input  wire       sys_clk,    // clock
    input  wire       driveA,     // plus drive
    input  wire       driveB,     // minus drive
    input  wire       lineCut,    // cable silent
    input  wire       pulseMode,  // only link pulses
    output reg        rxSymValid, // line bit
    output reg  [1:0] rxMlt,      // line level
    output reg        rxEnergy,   // energy
    output reg        rxPulseLike // pulse energy
);
// ****************
// line model
// ****************
initial {rxSymValid, rxMlt, rxEnergy, rxPulseLike} = 5'h00;
always @(posedge sys_clk) begin
    rxSymValid  <= 1'b1;
    rxMlt       <= lineCut ? 2'h0 : {driveB, driveA | driveB};
    rxEnergy    <= !lineCut;
    rxPulseLike <= pulseMode;
end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the coding path
`timescale 1ns/1ps
module tb;
// ****************
// bench
// ****************
localparam        HOLD = 200;
localparam [79:0] CGT  = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
                          5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
reg         sys_clk, nrst, txEnable, txError, scrBypass, lineCut, pulseMode, monOn, inFrame, prevLvl;
reg  [3:0]  txNibble;
reg  [4:0]  straps;
reg  [9:0]  win;
reg  [31:0] rec, recA;
reg  [4:0]  expQ[$];
integer     err_count, cmp_count, seed, i, k, len, bitCnt;
wire        txDriveA, txDriveB, sigDetect, rxLocked, rxSymStrobe, rxSymValid, rxEnergy, rxPulseLike;
wire [4:0]  rxSymbol;
wire [1:0]  rxMlt;
wire        lineBit = (txDriveA | txDriveB) ^ prevLvl;
fepcs_coding #(.HOLD_CYC(HOLD)) DUT (.sys_clk(sys_clk), .nrst(nrst), .txEnable(txEnable), .txNibble(txNibble),
    .txError(txError), .station_address_straps(straps), .scrBypass(scrBypass), .rxSymValid(rxSymValid),
    .rxMlt(rxMlt), .rxEnergy(rxEnergy), .rxPulseLike(rxPulseLike), .txDriveA(txDriveA), .txDriveB(txDriveB),
    .sigDetect(sigDetect), .rxLocked(rxLocked), .rxSymbol(rxSymbol), .rxSymStrobe(rxSymStrobe));
fepcs_link_partner LP (.sys_clk(sys_clk), .driveA(txDriveA), .driveB(txDriveB), .lineCut(lineCut),
    .pulseMode(pulseMode), .rxSymValid(rxSymValid), .rxMlt(rxMlt), .rxEnergy(rxEnergy), .rxPulseLike(rxPulseLike));
task automatic chk(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task complete_run;
    begin
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
endtask
task waitLock(input v, input integer n);
    integer c;
    begin
        c = 0;
        while (rxLocked !== v && c < n) begin
            @(negedge sys_clk);
            c = c + 1;
        end
        chk(rxLocked, v);
        if (rxLocked !== v) complete_run;
    end
endtask
// line decoder: level changes mark ones, groups aligned on the start pair
always @(posedge sys_clk) begin
    prevLvl <= txDriveA | txDriveB;
    win <= {win[8:0], lineBit};
    rec <= {rec[30:0], lineBit};
    if (monOn && !inFrame && {win[8:0], lineBit} == 10'h311) begin
        inFrame <= 1'b1;
        bitCnt <= 0;
        chk(5'h18, expQ.size() > 0 ? expQ.pop_front() : 6'h20);
        chk(5'h11, expQ.size() > 0 ? expQ.pop_front() : 6'h20);
    end else if (inFrame) begin
        bitCnt <= (bitCnt == 4) ? 0 : bitCnt + 1;
        if (bitCnt == 4) begin
            if (expQ.size() > 0 && expQ[0] == 5'h1f) inFrame <= 1'b0;
            chk({win[3:0], lineBit}, expQ.size() > 0 ? expQ.pop_front() : 6'h20);
        end
    end
end
initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
end
initial begin
    {nrst, txEnable, txError, scrBypass, lineCut, pulseMode, monOn, inFrame, prevLvl} = 9'h000;
    txNibble = 4'h0;
    straps = 5'h06;
    win = 10'h000;
    rec = 32'h0;
    bitCnt = 0;
    err_count = 0;
    cmp_count = 0;
    seed = 36;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (40) @(negedge sys_clk);
    recA = rec;
    chk(recA === 32'hffffffff, 1'b0);
    nrst = 1'b0;
    straps = 5'h19;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk(rec === recA, 1'b0);
    $display("seed test done");
    waitLock(1'b1, 300);
    repeat (100) begin
        @(posedge sys_clk);
        #1;
        if (rxSymStrobe) chk(rxSymbol, 5'h1f);
    end
    repeat (3 * HOLD) @(negedge sys_clk);
    chk(rxLocked, 1'b1);
    $display("lock test done");
    lineCut = 1'b1;
    repeat (100) @(negedge sys_clk);
    chk(rxLocked, 1'b1);
    waitLock(1'b0, HOLD + 20);
    lineCut = 1'b0;
    waitLock(1'b1, 300);
    pulseMode = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(sigDetect, 1'b0);
    pulseMode = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(sigDetect, 1'b1);
    $display("hold and detect test done");
    scrBypass = 1'b1;
    repeat (20) @(negedge sys_clk);
    monOn = 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
        len = 3 + ($random(seed) & 3);
        expQ.push_back(5'h18);
        expQ.push_back(5'h11);
        for (k = 2; k < len; k = k + 1) expQ.push_back((i == 9) ? 5'h04 : CGT[i * 5 +: 5]);
        expQ.push_back(5'h0d);
        expQ.push_back(5'h07);
        expQ.push_back(5'h1f);
        txNibble = i[3:0];
        txError = (i == 9);
        txEnable = 1'b1;
        repeat (5 * len) @(negedge sys_clk);
        txEnable = 1'b0;
        txError = 1'b0;
        repeat (20 + 5 * ($random(seed) & 1)) @(negedge sys_clk);
    end
    k = 0;
    while (expQ.size() > 0 && k < 200) begin
        @(negedge sys_clk);
        k = k + 1;
    end
    chk(expQ.size(), 0);
    $display("frame test done");
    complete_run;
end
endmodule
